// ### design/lic_level_interrupt_control.sv
`timescale 1ns/1ns
`default_nettype none
module lic_level_interrupt_control import lic_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire lic_regreq_t regReq,
  output lic_regreq_t regRsp,
  input wire logic enableInstr,
  input wire logic disableInstr,
  input wire logic returnFromService,
  input wire logic irqAck,
  input wire logic [LIC_SOURCES-1:0] srcPending,
  input wire logic [LIC_SOURCES-1:0] srcEnable,
  output lic_req_t irqOut
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] levelMask_q;
  logic [7:0] levelPrio_q;
  logic [7:0] sysMode_q;
  logic [7:0] levelStatus_q;
  logic [LIC_SOURCES-1:0] srcReq_q;
  lic_regreq_t regRsp_q;
  lic_req_t irqOut_q;
  lic_req_t irqOut_d;
  logic [LIC_LEVELS-1:0][2:0] rank;
  logic [7:0] levelRaw;
  logic [7:0] active;
  logic betterSeen;

  function automatic logic hit(input lic_regreq_t r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction

  assign regRsp = regRsp_q;
  assign irqOut = irqOut_q;

  lic_prio_order uOrder (
    .prio(levelPrio_q),
    .rank(rank)
  );

  // ----------------------------------------------------------------
  // Mask and priority registers
  // ----------------------------------------------------------------
  // Cleared at reset only to keep simulation clean; nothing relies on it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      levelMask_q <= LIC_MASK_RST;
    end else if (hit(regReq, LIC_ADDR_MASK)) begin
      levelMask_q <= regReq.data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      levelPrio_q <= LIC_PRIO_RST;
    end else if (hit(regReq, LIC_ADDR_PRIO)) begin
      levelPrio_q <= regReq.data;
    end
  end

  // ----------------------------------------------------------------
  // System mode register
  // ----------------------------------------------------------------
  // Enable and return win over the clear from acknowledge or disable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sysMode_q <= LIC_MODE_RST;
    end else begin
      if (hit(regReq, LIC_ADDR_MODE)) begin
        sysMode_q <= regReq.data;
      end
      if (enableInstr || returnFromService) begin
        sysMode_q[LIC_MODE_GLOBAL] <= 1'b1;
      end else if (disableInstr || irqAck) begin
        sysMode_q[LIC_MODE_GLOBAL] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-level request flags
  // ----------------------------------------------------------------
  always_comb begin
    levelRaw = 8'h00;
    for (int s = 0; s < LIC_SOURCES; s++) begin
      if (srcPending[s] && srcEnable[s]) begin
        levelRaw[LIC_SRC_LEVEL[s]] = 1'b1;
      end
    end
  end

  // Status is captured regardless of mask and global enable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      levelStatus_q <= 8'h00;
      srcReq_q <= '0;
    end else begin
      levelStatus_q <= levelRaw;
      srcReq_q <= srcPending & srcEnable;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRsp_q <= '0;
    end else begin
      regRsp_q.wr <= 1'b0;
      regRsp_q.rd <= regReq.rd;
      regRsp_q.addr <= regReq.addr;
      if (!regReq.rd) begin
        regRsp_q.data <= LIC_RD_UNMAPPED;
      end else begin
        unique case (regReq.addr)
          LIC_ADDR_STATUS: regRsp_q.data <= levelStatus_q;
          LIC_ADDR_MASK: regRsp_q.data <= levelMask_q;
          LIC_ADDR_MODE: regRsp_q.data <= sysMode_q;
          LIC_ADDR_PRIO: regRsp_q.data <= levelPrio_q;
          default: regRsp_q.data <= LIC_RD_UNMAPPED;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // Linear scans: eight levels and eighteen sources are cheap enough
  always_comb begin
    active = levelStatus_q & levelMask_q
      & {8{sysMode_q[LIC_MODE_GLOBAL]}};
    irqOut_d = '0;
    for (int l = 0; l < LIC_LEVELS; l++) begin
      if (active[l] && (!irqOut_d.valid || rank[l] < rank[irqOut_d.level])) begin
        irqOut_d.valid = 1'b1;
        irqOut_d.level = 3'(l);
      end
    end
    // Lowest index source of the winning level, scanning downward
    for (int s = LIC_SOURCES - 1; s >= 0; s--) begin
      if (irqOut_d.valid && srcReq_q[s] && LIC_SRC_LEVEL[s] == irqOut_d.level) begin
        irqOut_d.vector = LIC_VEC_BASE + 8'({s[6:0], 1'b0});
      end
    end
    irqOut_d.fast = irqOut_d.valid && sysMode_q[LIC_MODE_FASTEN]
      && (sysMode_q[LIC_MODE_FSEL_LO +: 3] == irqOut_d.level);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqOut_q <= '0;
    end else begin
      irqOut_q <= irqOut_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  always_comb begin
    betterSeen = 1'b0;
    for (int l = 0; l < LIC_LEVELS; l++) begin
      if (irqOut_d.valid && active[l] && rank[l] < rank[irqOut_d.level]) begin
        betterSeen = 1'b1;
      end
    end
  end

  mask_gate_a: assert property (@(posedge clk) disable iff (!nrst)
    irqOut_q.valid |-> (($past(levelMask_q) & (8'h01 << irqOut_q.level)) != 8'h00))
    else $error("request presented on a masked level");
  global_gate_a: assert property (@(posedge clk) disable iff (!nrst)
    irqOut_q.valid |-> $past(sysMode_q[LIC_MODE_GLOBAL])
      && (($past(levelStatus_q) & (8'h01 << irqOut_q.level)) != 8'h00))
    else $error("request presented without global enable or pending level");
  enable_sets_a: assert property (@(posedge clk) disable iff (!nrst)
    enableInstr |=> sysMode_q[LIC_MODE_GLOBAL])
    else $error("enable instruction did not set global bit");
  disable_clears_a: assert property (@(posedge clk) disable iff (!nrst)
    disableInstr && !enableInstr && !returnFromService |=> !sysMode_q[LIC_MODE_GLOBAL])
    else $error("disable instruction did not clear global bit");
  return_sets_a: assert property (@(posedge clk) disable iff (!nrst)
    returnFromService |=> sysMode_q[LIC_MODE_GLOBAL] ##1 1'b1)
    else $error("return did not restore global bit");
  status_track_a: assert property (@(posedge clk) disable iff (!nrst)
    ##1 levelStatus_q == $past(levelRaw))
    else $error("level status does not follow requests");
  best_level_a: assert property (@(posedge clk) disable iff (!nrst)
    irqOut_q.valid |-> !$past(betterSeen))
    else $error("a higher ranked level was passed over");
  ack_blocks_a: assert property (@(posedge clk) disable iff (!nrst)
    irqAck && !enableInstr && !returnFromService |=> ##1 !irqOut_q.valid)
    else $error("request still presented after acknowledge");
  fast_sel_a: assert property (@(posedge clk) disable iff (!nrst)
    irqOut_q.fast |-> irqOut_q.valid && $past(sysMode_q[LIC_MODE_FASTEN]))
    else $error("fast hit without fast enable");

endmodule
`default_nettype wire

// ### design/lic_pkg.sv
// Notes on behaviour
// - Eight levels, each with its own mask bit
// - Mask bit 0 blocks level, 1 allows
// - Mask content undefined until software writes it
// - Priority content undefined until software writes it
// - Groups: A=0,1; B=2,3,4; C=5,6,7
// - Bits 7,4,1 order groups; 001=B>C>A, 101=C>B>A
// - Bit 0 orders level 0 against 1
// - Bit 5 orders group C, bit 6 subgroup
// - Highest priority enabled level is served first
// - Same level: lowest vector address wins, fixed
// - Request status read-only, one flag per level
// - Reset clears fast enable and global enable
// - Enable sets, disable clears global bit; gates all
// - Request needs global, level unmask and source enable
// - Level 6 port zero bits 0-3, level 7 bits 4-7
// - Status bit n is level n, reset zero, always readable
// - Return from service sets global enable again
package lic_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] LIC_ADDR_STATUS = 8'hDC;
  localparam logic [7:0] LIC_ADDR_MASK = 8'hDD;
  localparam logic [7:0] LIC_ADDR_MODE = 8'hDE;
  localparam logic [7:0] LIC_ADDR_PRIO = 8'hFF;
  localparam logic [7:0] LIC_RD_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int LIC_MODE_GLOBAL = 0;
  localparam int LIC_MODE_FASTEN = 1;
  localparam int LIC_MODE_FSEL_LO = 2;
  localparam int LIC_PRIO_A = 0;
  localparam int LIC_PRIO_C = 5;
  localparam int LIC_PRIO_SUBC = 6;
  localparam logic [7:0] LIC_MASK_RST = 8'h00;
  localparam logic [7:0] LIC_PRIO_RST = 8'h00;
  localparam logic [7:0] LIC_MODE_RST = 8'h00;

  // ----------------------------------------------------------------
  // Sources and vectors
  // ----------------------------------------------------------------
  localparam int LIC_LEVELS = 8;
  localparam int LIC_SOURCES = 18;
  localparam logic [7:0] LIC_VEC_BASE = 8'hDC;
  // Level of each source, index 0 has the lowest vector address
  localparam logic [LIC_SOURCES-1:0][2:0] LIC_SRC_LEVEL = {
    3'h7, 3'h7, 3'h7, 3'h7, 3'h6, 3'h6, 3'h6, 3'h6, 3'h5,
    3'h5, 3'h5, 3'h4, 3'h3, 3'h3, 3'h2, 3'h1, 3'h0, 3'h0};
  localparam int LIC_PORT_ZERO_FIRST = 10;

  // ----------------------------------------------------------------
  // Group identifiers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {LIC_GRP_A, LIC_GRP_B, LIC_GRP_C} lic_grp_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } lic_regreq_t;

  typedef struct packed {
    logic valid;
    logic fast;
    logic [2:0] level;
    logic [7:0] vector;
  } lic_req_t;

endpackage

// ### design/lic_prio_order.sv
`timescale 1ns/1ns
`default_nettype none
module lic_prio_order import lic_pkg::*; (
  input wire logic [7:0] prio,
  output logic [LIC_LEVELS-1:0][2:0] rank
);

  lic_grp_t ord [3];
  logic [2:0] base [3];
  logic [2:0] acc;

  function automatic logic [2:0] grpSize(input lic_grp_t g);
    grpSize = (g == LIC_GRP_A) ? 3'h2 : 3'h3;
  endfunction

  // ----------------------------------------------------------------
  // Group order and level ranks, 0 is the highest
  // ----------------------------------------------------------------
  // Unlisted codes 000 and 111 fold to A>B>C so no tie can arise
  always_comb begin
    unique case ({prio[7], prio[4], prio[1]})
      3'b001: begin ord[0] = LIC_GRP_B; ord[1] = LIC_GRP_C; ord[2] = LIC_GRP_A; end
      3'b010: begin ord[0] = LIC_GRP_A; ord[1] = LIC_GRP_B; ord[2] = LIC_GRP_C; end
      3'b011: begin ord[0] = LIC_GRP_B; ord[1] = LIC_GRP_A; ord[2] = LIC_GRP_C; end
      3'b100: begin ord[0] = LIC_GRP_C; ord[1] = LIC_GRP_A; ord[2] = LIC_GRP_B; end
      3'b101: begin ord[0] = LIC_GRP_C; ord[1] = LIC_GRP_B; ord[2] = LIC_GRP_A; end
      3'b110: begin ord[0] = LIC_GRP_A; ord[1] = LIC_GRP_C; ord[2] = LIC_GRP_B; end
      default: begin ord[0] = LIC_GRP_A; ord[1] = LIC_GRP_B; ord[2] = LIC_GRP_C; end
    endcase
    acc = 3'h0;
    base[0] = 3'h0;
    base[1] = 3'h0;
    base[2] = 3'h0;
    for (int i = 0; i < 3; i++) begin
      base[ord[i]] = acc;
      acc = acc + grpSize(ord[i]);
    end
    // Group A pair
    rank[0] = base[LIC_GRP_A] + {2'h0, prio[LIC_PRIO_A]};
    rank[1] = base[LIC_GRP_A] + {2'h0, ~prio[LIC_PRIO_A]};
    // Group B has no programmable order
    rank[2] = base[LIC_GRP_B];
    rank[3] = base[LIC_GRP_B] + 3'h1;
    rank[4] = base[LIC_GRP_B] + 3'h2;
    // Group C: level 5 against the 6/7 subgroup, then inside it
    rank[5] = base[LIC_GRP_C] + (prio[LIC_PRIO_C] ? 3'h2 : 3'h0);
    rank[6] = base[LIC_GRP_C] + (prio[LIC_PRIO_C] ? 3'h0 : 3'h1)
      + {2'h0, prio[LIC_PRIO_SUBC]};
    rank[7] = base[LIC_GRP_C] + (prio[LIC_PRIO_C] ? 3'h0 : 3'h1)
      + {2'h0, ~prio[LIC_PRIO_SUBC]};
  end

endmodule
`default_nettype wire

// ### verification/lic_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module lic_cpu_model import lic_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic autoAck,
  input wire lic_req_t irqOut,
  output logic irqAck,
  output logic returnFromService,
  output logic [7:0] served
);
  logic [3:0] busy_q;

  // -------------------------------------------------------------
  // Core side: take a request, run a short routine, return
  // -------------------------------------------------------------
  // Busy window outlasts the two-cycle drop of valid, so a stale
  // request is never acknowledged twice
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqAck <= 1'b0;
      returnFromService <= 1'b0;
      busy_q <= 4'h0;
      served <= 8'h00;
    end else begin
      irqAck <= 1'b0;
      returnFromService <= 1'b0;
      if (busy_q != 4'h0) begin
        busy_q <= busy_q - 4'h1;
        returnFromService <= (busy_q == 4'h1);
      end else if (autoAck && irqOut.valid) begin
        irqAck <= 1'b1;
        busy_q <= 4'h6;
        served <= served + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/tb_level_interrupt_control.sv
`timescale 1ns/1ns
`default_nettype none
module tb_level_interrupt_control import lic_pkg::*;;
  logic clk;
  logic nrst;
  lic_regreq_t regReq;
  lic_regreq_t regRsp;
  logic enableInstr;
  logic disableInstr;
  logic returnFromService;
  logic irqAck;
  logic autoAck;
  logic [LIC_SOURCES-1:0] srcPending;
  logic [LIC_SOURCES-1:0] srcEnable;
  lic_req_t irqOut;
  logic [7:0] served;
  logic [31:0] seed;
  logic [7:0] v;
  logic [7:0] d;
  int j;
  int n_fail;
  int checks_done;
  // Priority cases: code, pending sources, winning level
  logic [7:0] pTab [6] = '{8'h02, 8'h82, 8'h00, 8'h01, 8'h92, 8'hB2};
  logic [17:0] sTab [6] = '{18'h89, 18'h89, 18'h05, 18'h05, 18'h480, 18'h480};
  logic [2:0] lTab [6] = '{3'h2, 3'h5, 3'h0, 3'h1, 3'h5, 3'h6};

  lic_level_interrupt_control dut_u (.clk(clk), .nrst(nrst), .regReq(regReq),
    .regRsp(regRsp), .enableInstr(enableInstr), .disableInstr(disableInstr),
    .returnFromService(returnFromService), .irqAck(irqAck), .srcPending(srcPending),
    .srcEnable(srcEnable), .irqOut(irqOut));
  lic_cpu_model cpu_u (.clk(clk), .nrst(nrst), .autoAck(autoAck), .irqOut(irqOut),
    .irqAck(irqAck), .returnFromService(returnFromService), .served(served));

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Level of a source, sources listed in vector order
  function automatic logic [2:0] srcLevel(input int i);
    if (i < 3) return (i < 2) ? 3'h0 : 3'h1;
    if (i < 7) return (i < 4) ? 3'h2 : ((i < 6) ? 3'h3 : 3'h4);
    return (i < 10) ? 3'h5 : ((i < 14) ? 3'h6 : 3'h7);
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic regWrite(input logic [7:0] a, input logic [7:0] dw);
    @(posedge clk);
    regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, data: dw};
    @(posedge clk);
    regReq <= '0;
  endtask
  // Data is registered on the taking edge itself and read 1 ns after it
  task automatic regRead(input logic [7:0] a, output logic [7:0] dr);
    @(posedge clk);
    regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
    @(posedge clk);
    regReq <= '0;
    #1;
    dr = regRsp.data;
  endtask
  task automatic instr(input logic en);
    @(posedge clk);
    enableInstr <= en;
    disableInstr <= !en;
    @(posedge clk);
    enableInstr <= 1'b0;
    disableInstr <= 1'b0;
  endtask
  task automatic setPending(input logic [17:0] p);
    @(posedge clk);
    srcPending <= p;
    tick(3);
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    regReq = '0;
    enableInstr = 1'b0;
    disableInstr = 1'b0;
    srcPending = '0;
    srcEnable = '1;
    autoAck = 1'b0;
    nrst = 1'b0;
    seed = 32'h8E4B51E8;
    n_fail = 0;
    checks_done = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    regRead(LIC_ADDR_MODE, v);
    check(v & 8'h03, 8'h00);
    regRead(LIC_ADDR_STATUS, v);
    check(v, 8'h00);
    regRead(8'h10, v);
    check(v, 8'h00);
    // Global is off after reset, so mask writes are allowed here
    for (int i = 0; i < 4; i++) begin
      seed = xorshift(seed);
      d = seed[7:0];
      regWrite(LIC_ADDR_MASK, d);
      regRead(LIC_ADDR_MASK, v);
      check(v, d);
      regWrite(LIC_ADDR_PRIO, seed[15:8]);
      regRead(LIC_ADDR_PRIO, v);
      check(v, seed[15:8]);
    end
    regWrite(LIC_ADDR_STATUS, 8'hFF);
    regRead(LIC_ADDR_STATUS, v);
    check(v, 8'h00);
    regWrite(LIC_ADDR_MASK, 8'hFF);
    regWrite(LIC_ADDR_PRIO, 8'h00);
    $display("test registers done");
    setPending(18'h40);
    instr(1'b1);
    regRead(LIC_ADDR_MODE, v);
    check({7'h0, v[0]}, 8'h01);
    check({7'h0, irqOut.valid}, 8'h01);
    instr(1'b0);
    tick(2);
    check({7'h0, irqOut.valid}, 8'h00);
    instr(1'b1);
    $display("test global done");
    for (int i = 0; i < LIC_SOURCES; i++) begin
      setPending(18'(1) << i);
      check({7'h0, irqOut.valid}, 8'h01);
      check({5'h0, irqOut.level}, {5'h0, srcLevel(i)});
      check(irqOut.vector, 8'(LIC_VEC_BASE + 2 * i));
    end
    setPending(18'h300);
    check(irqOut.vector, 8'hEC);
    $display("test sources done");
    for (int k = 0; k < 6; k++) begin
      regWrite(LIC_ADDR_PRIO, pTab[k]);
      setPending(sTab[k]);
      check({5'h0, irqOut.level}, {5'h0, lTab[k]});
    end
    $display("test priority done");
    seed = xorshift(seed);
    j = seed % LIC_SOURCES;
    instr(1'b0);
    regWrite(LIC_ADDR_MASK, ~(8'h01 << srcLevel(j)));
    instr(1'b1);
    setPending(18'(1) << j);
    check({7'h0, irqOut.valid}, 8'h00);
    regRead(LIC_ADDR_STATUS, v);
    check(v, 8'h01 << srcLevel(j));
    @(posedge clk);
    srcEnable <= ~(18'(1) << j);
    tick(3);
    regRead(LIC_ADDR_STATUS, v);
    check(v, 8'h00);
    $display("test mask done");
    instr(1'b0);
    regWrite(LIC_ADDR_MASK, 8'hFF);
    // Direct mode write: global on, fast enable, fast select level 2
    regWrite(LIC_ADDR_MODE, 8'h0B);
    @(posedge clk);
    srcEnable <= '1;
    srcPending <= 18'h08;
    tick(3);
    check({7'h0, irqOut.valid}, 8'h01);
    check({7'h0, irqOut.fast}, 8'h01);
    @(posedge clk);
    autoAck <= 1'b1;
    // Bounded wait for a second service, only reachable after return
    for (int w = 0; w < 200 && served < 8'h02; w++) begin
      tick(1);
    end
    check({7'h0, served >= 8'h02}, 8'h01);
    $display("test service done");
    report_and_stop();
  end
endmodule
`default_nettype wire
